/* bench/cca_core_assertions.sv */
/*
  cca_core_assertions: port checks of cca_core, bound to every instance.
  assumes an AXI4-Lite master and a one-cycle program memory.
*/
`default_nettype none

module cca_core_assertions (
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_we,
  input wire logic [15:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // straight-line fetch history
  logic rd_r;
  logic [3:0] ok_r;
  function automatic logic plain(input logic [15:0] w);
    return w[15] || w[15:12] == 4'h1 || w[15:12] == 4'h4;
  endfunction
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_r <= 1'b0;
      ok_r <= 4'h0;
    end else begin
      rd_r <= prog_rd;
      ok_r <= {ok_r[2:0], rd_r && plain(prog_rdata)};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================
  // checks
  fetch_seq_a: assert property (&ok_r && rd_r && plain(prog_rdata) |->
    prog_rd && prog_addr == $past(prog_addr) + 16'h1) else $error("fetch out of line");
  we_pulse_a: assert property (prog_we |=> !prog_we)
    else $error("write pulse too long");
  reset_idle_a: assert property ($rose(resetn) |->
    s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !prog_rd) else $error("bad reset");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write answer");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read answer");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
endmodule // cca_core_assertions

bind cca_core cca_core_assertions u_cca_core_assertions (.clock, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr, .prog_rd, .prog_we, .prog_rdata);

`default_nettype wire

/* bench/cca_prog_mem.sv */
/*
  cca_prog_mem: program memory model on the core's program bus.
  assumes data are due the cycle after a read request.
*/
`default_nettype none

module cca_prog_mem (
  input wire logic clock,
  input wire logic [15:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_we,
  input wire logic [15:0] prog_wdata,
  output logic [15:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // storage, filled with no-ops
  logic [15:0] mem [0:4095];
  initial begin
    prog_rdata = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h8000;
  end
  always @(posedge clock) begin
    if (prog_rd) prog_rdata <= mem[prog_addr[11:0]];
    else prog_rdata <= ~prog_rdata;
    if (prog_we) mem[prog_addr[11:0]] <= prog_wdata;
  end
endmodule // cca_prog_mem

`default_nettype wire

/* bench/tb_top.sv */
/*
  tb_top: self-checking bench of cca_core with a program memory model.
  assumes the package, design and bench models compiled first.
*/
`default_nettype none

module tb_top
  import cca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // signals and instances
  logic clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, prog_rd, prog_we, prog_ext;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] prog_addr, prog_wdata, prog_rdata;
  int num_errors = 0;
  int num_checks = 0;
  cca_core u_cca_core (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr,
    .prog_rd, .prog_we, .prog_wdata, .prog_ext, .prog_rdata);
  cca_prog_mem u_cca_prog_mem (.clock, .prog_addr, .prog_rd, .prog_we, .prog_wdata, .prog_rdata);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic run(input logic [31:0] c, input logic e);
    do_reset();
    axi_wr(REG_CTRL, c, RESP_OKAY);
    repeat (40) @(posedge clock);
    while (prog_rd !== 1'b1) @(posedge clock);
    chk(32'(prog_ext), 32'(e));
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd_chk(8'h10, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    axi_wr(8'h10, 32'hF, RESP_SLVERR);
    axi_wr(REG_STAT, 32'hF, RESP_OKAY);
    rd_chk(REG_STAT, 32'h10F, 32'h0, RESP_OKAY);
    rd_chk(REG_CORE, 32'hFF, 32'h0, RESP_OKAY);
    $display("regs done");
  endtask
  task automatic t_prot();
    for (int m = 0; m < 4; m++) begin
      axi_wr(REG_CTRL, 32'h8 | (32'(m) << 1), RESP_OKAY);
      rd_chk(REG_STAT, 32'h100, (m == 3) ? 32'h0 : 32'h100, RESP_OKAY);
    end
    $display("protect done");
  endtask
  task automatic alu_case(input logic [7:0] i, input cca_aluop_t op, input logic [7:0] k,
    input logic [7:0] ea, input logic [3:0] ef);
    u_cca_prog_mem.mem[4] = {OP_ALUL, ALU_PASS, 1'b0, i};
    u_cca_prog_mem.mem[5] = {OP_ALUL, op, 1'b0, k};
    u_cca_prog_mem.mem[6] = {OP_GOTO, 12'h006};
    run(32'h1, 1'b0);
    rd_chk(REG_CORE, 32'hFF, {24'h0, ea}, RESP_OKAY);
    rd_chk(REG_STAT, 32'hF, {28'h0, ef}, RESP_OKAY);
  endtask
  task automatic t_alu();
    alu_case(8'hFF, ALU_ADD, 8'h01, 8'h00, 4'h7);
    alu_case(8'h40, ALU_ADD, 8'h40, 8'h80, 4'h8);
    alu_case(8'h08, ALU_ADD, 8'h08, 8'h10, 4'h2);
    alu_case(8'h01, ALU_SUB, 8'h80, 8'h7F, 4'h9);
    alu_case(8'h05, ALU_SUB, 8'h05, 8'h00, 4'h7);
    alu_case(8'h0F, ALU_AND, 8'hF0, 8'h00, 4'h4);
    alu_case(8'hA5, ALU_XOR, 8'hA5, 8'h00, 4'h4);
    alu_case(8'h0F, ALU_IOR, 8'hF0, 8'hFF, 4'h0);
    $display("alu done");
  endtask
  task automatic t_mul();
    logic [15:0] p [0:10];
    p = '{16'h1EC8, 16'h2320, 16'h1E0D, 16'h4020, 16'h1E10, 16'h2306, 16'h1E00, 16'h2307, 16'h1E0D,
      16'h7003, 16'h500E};
    foreach (p[i]) u_cca_prog_mem.mem[i + 4] = p[i];
    run(32'h5, 1'b1);
    rd_chk(REG_PROD, 32'hFFFF, 32'h0A28, RESP_OKAY);
    rd_chk(REG_CORE, 32'hFF, 32'h0D, RESP_OKAY);
    chk(32'(u_cca_prog_mem.mem[16]), 32'h0D0D);
    $display("multiply done");
  endtask
  task automatic t_tbl();
    logic [15:0] p [0:8];
    p = '{16'h1E10, 16'h2306, 16'h1E00, 16'h2307, 16'h6130, 16'h0D30, 16'h6003, 16'h0230, 16'h500C};
    foreach (p[i]) u_cca_prog_mem.mem[i + 4] = p[i];
    u_cca_prog_mem.mem[16] = 16'hC3A5;
    run(32'h7, 1'b0);
    rd_chk(REG_CORE, 32'hFF, 32'h2C, RESP_OKAY);
    rd_chk(REG_STAT, 32'hF, 32'h9, RESP_OKAY);
    $display("table done");
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    do_reset();
    t_regs();
    t_prot();
    t_alu();
    t_mul();
    t_tbl();
    end_of_test();
  end
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire

/* verilog/cca_alu.sv */
/*
  Combinational 8-bit ALU with flag outputs and optional 8x8 multiplier.
  Assumes the core picks which flags to keep for each operation.
*/
`default_nettype none

module cca_alu
  import cca_pkg::*;
#(
  parameter bit HAS_MUL = 1'b1
) (
  cca_alu_if.alu port
);

  // ==========================================================
  // arithmetic and logic
  always_comb begin
    logic [7:0] bb;
    logic ci;
    logic [8:0] sum;
    logic [4:0] nib;
    logic c_in7;
    bb = (port.op == ALU_SUB) ? ~port.b : port.b;
    ci = (port.op == ALU_SUB) ? 1'b1 : ((port.op == ALU_ADDC) ? port.cin : 1'b0);
    sum = {1'b0, port.a} + {1'b0, bb} + {8'h00, ci};
    nib = {1'b0, port.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    c_in7 = port.a[7] ^ bb[7] ^ sum[7];
    port.c = sum[8];
    port.nibc = nib[4];
    port.sovf = c_in7 ^ sum[8];
    unique case (port.op)
      ALU_ADD, ALU_ADDC, ALU_SUB: port.y = sum[7:0];
      ALU_AND: port.y = port.a & port.b;
      ALU_IOR: port.y = port.a | port.b;
      ALU_XOR: port.y = port.a ^ port.b;
      ALU_RLC: begin
        port.y = {port.a[6:0], port.cin};
        port.c = port.a[7];
      end
      ALU_PASS: port.y = port.a;
    endcase
    port.z = (port.y == 8'h00);
  end

  // ==========================================================
  // multiplier
  assign port.prod = HAS_MUL ? ({8'h00, port.a} * {8'h00, port.b}) : 16'h0000;

endmodule // cca_alu

`default_nettype wire

/* verilog/cca_alu_if.sv */
/*
  Operand and result carrier between the core sequencer and its ALU.
  Assumes cca_pkg compiled first.
*/
`default_nettype none

interface cca_alu_if;
  import cca_pkg::*;
  logic [7:0] a;
  logic [7:0] b;
  cca_aluop_t op;
  logic cin;
  logic [7:0] y;
  logic c;
  logic nibc;
  logic z;
  logic sovf;
  logic [15:0] prod;
  modport core (output a, output b, output op, output cin,
                input y, input c, input nibc, input z, input sovf, input prod);
  modport alu (input a, input b, input op, input cin,
               output y, output c, output nibc, output z, output sovf, output prod);
endinterface : cca_alu_if

`default_nettype wire

/* verilog/cca_core.sv */
/*
  Two-stage 8-bit core datapath: program-bus sequencer, data memory with
  mapped core registers, ALU and multiplier, AXI4-Lite control slave.
  Assumes a synchronous program memory returning data one cycle after the
  address and all inputs synchronous to clock.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none

module cca_core
  import cca_pkg::*;
#(
  parameter int unsigned INT_WORDS = INT_WORDS_DEF,
  parameter bit HAS_MUL = 1'b1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] prog_addr,
  output logic prog_rd,
  output logic prog_we,
  output logic [15:0] prog_wdata,
  output logic prog_ext,
  input wire logic [15:0] prog_rdata
);

  localparam logic [16:0] INT_LIMIT = 17'(INT_WORDS);

  // ==========================================================
  // state
  logic run_r, run_nxt, prot_req_r, prot_req_nxt;
  cca_mode_t mode_r, mode_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic [15:0] ip_r, ip_nxt, paddr_r, paddr_nxt, pwdata_r, pwdata_nxt;
  logic prd_r, prd_nxt, pwe_r, pwe_nxt, pext_r, pext_nxt;
  cca_kind_t akind_r, akind_nxt, dkind_r, dkind_nxt;
  logic [7:0] acc_r, acc_nxt, iplatch_r, iplatch_nxt, fsr_r, fsr_nxt;
  logic [15:0] tptr_r, tptr_nxt, prod_r, prod_nxt;
  logic [3:0] flags_r, flags_nxt;
  logic [7:0] tdst_r, tdst_nxt;
  logic tsel_r, tsel_nxt;
  logic [7:0] gpr_r [0:255];
  logic gpr_we;
  logic [7:0] gpr_wa, gpr_wd;
  logic prot_eff, idle;

  cca_alu_if alu_bus ();

  cca_alu #(.HAS_MUL(HAS_MUL)) u_alu (
    .port(alu_bus.alu)
  );

  assign prot_eff = (mode_r == MODE_PMCU) || (prot_req_r && (mode_r != MODE_EXT));
  assign idle = !run_r && (akind_r == K_NONE) && (dkind_r == K_NONE);

  // ==========================================================
  // data memory access helpers
  function automatic logic [7:0] eff_addr(input logic [7:0] f);
    eff_addr = (f == SFR_INDF) ? fsr_r : f;
  endfunction

  function automatic logic [7:0] rd_reg(input logic [7:0] ea);
    unique case (ea)
      SFR_IPL: rd_reg = ip_r[7:0];
      SFR_IPLATCH: rd_reg = iplatch_r;
      SFR_STATUS: rd_reg = {4'h0, flags_r};
      SFR_ACC: rd_reg = acc_r;
      SFR_PRODL: rd_reg = prod_r[7:0];
      SFR_PRODH: rd_reg = prod_r[15:8];
      SFR_TPTRL: rd_reg = tptr_r[7:0];
      SFR_TPTRH: rd_reg = tptr_r[15:8];
      SFR_FSR: rd_reg = fsr_r;
      SFR_INDF: rd_reg = 8'h00;
      default: rd_reg = gpr_r[ea];
    endcase
  endfunction

  // ==========================================================
  // bus slave
  always_comb begin
    logic [7:0] ra;
    run_nxt = run_r;
    mode_nxt = mode_r;
    prot_req_nxt = prot_req_r;
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ra = {s_axi_araddr[7:2], 2'b00};
    if (s_axi_awvalid && awready_r) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && wready_r) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      unique case (awaddr_r)
        REG_CTRL: begin
          if (wstrb0_r) begin
            run_nxt = wdata_r[CTRL_RUN_BIT];
            mode_nxt = cca_mode_t'(wdata_r[CTRL_MODE_LSB +: 2]);
            prot_req_nxt = wdata_r[CTRL_PROT_BIT];
          end
        end
        REG_STAT, REG_CORE, REG_PROD: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      rdata_nxt = 32'h00000000;
      unique case (ra)
        REG_CTRL: rdata_nxt = {28'h0000000, prot_req_r, mode_r, run_r};
        REG_STAT: rdata_nxt = {22'h000000, idle, prot_eff, 4'h0, flags_r};
        REG_CORE: rdata_nxt = {ip_r, 8'h00, acc_r};
        REG_PROD: rdata_nxt = {16'h0000, prod_r};
        default: rresp_nxt = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run_r <= 1'b0;
      mode_r <= MODE_MCU;
      prot_req_r <= 1'b0;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb0_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      run_r <= run_nxt;
      mode_r <= mode_nxt;
      prot_req_r <= prot_req_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ==========================================================
  // sequencer and execute stage
  always_comb begin
    logic [15:0] insn;
    logic [7:0] ea, src, wa, wd;
    logic we, flush, tbl_go, wr_ok;
    cca_aluop_t aop;
    insn = prog_rdata;
    ea = eff_addr(prog_rdata[7:0]);
    src = eff_addr({3'b000, prog_rdata[12:8]});
    aop = cca_aluop_t'(prog_rdata[11:9]);
    we = 1'b0;
    wa = ea;
    wd = 8'h00;
    flush = 1'b0;
    tbl_go = 1'b0;
    wr_ok = 1'b1;
    ip_nxt = ip_r;
    acc_nxt = acc_r;
    iplatch_nxt = iplatch_r;
    fsr_nxt = fsr_r;
    tptr_nxt = tptr_r;
    prod_nxt = prod_r;
    flags_nxt = flags_r;
    tdst_nxt = tdst_r;
    tsel_nxt = tsel_r;
    paddr_nxt = paddr_r;
    pwdata_nxt = pwdata_r;
    prd_nxt = 1'b0;
    pwe_nxt = 1'b0;
    akind_nxt = K_NONE;
    dkind_nxt = akind_r;
    alu_bus.a = rd_reg(ea);
    alu_bus.b = acc_r;
    alu_bus.op = aop;
    alu_bus.cin = flags_r[FLG_C];
    if (dkind_r == K_FETCH) begin
      unique case (insn[15:12])
        OP_ALUF, OP_ALUL: begin
          if (insn[15:12] == OP_ALUL) begin
            alu_bus.a = insn[7:0];
          end
          if ((insn[15:12] == OP_ALUF) && insn[8]) begin
            we = 1'b1;
            wd = alu_bus.y;
          end else begin
            acc_nxt = alu_bus.y;
          end
          unique case (aop)
            ALU_ADD, ALU_ADDC, ALU_SUB: begin
              flags_nxt = {alu_bus.sovf, alu_bus.z, alu_bus.nibc, alu_bus.c};
            end
            ALU_RLC: begin
              flags_nxt[FLG_C] = alu_bus.c;
              flags_nxt[FLG_Z] = alu_bus.z;
            end
            ALU_AND, ALU_IOR, ALU_XOR, ALU_PASS: flags_nxt[FLG_Z] = alu_bus.z;
          endcase
        end
        OP_MOVP0, OP_MOVP1: begin
          we = 1'b1;
          wd = rd_reg(src);
        end
        OP_MUL: begin
          if (HAS_MUL) begin
            prod_nxt = alu_bus.prod;
          end
        end
        OP_GOTO: begin
          ip_nxt = {iplatch_r[7:4], insn[11:0]};
          flush = 1'b1;
        end
        OP_TBLRD: begin
          tbl_go = 1'b1;
          tdst_nxt = ea;
          tsel_nxt = insn[8];
          akind_nxt = K_TBL;
          prd_nxt = 1'b1;
          paddr_nxt = tptr_r;
        end
        OP_TBLWT: begin
          tbl_go = 1'b1;
          wr_ok = !(prot_eff && ({1'b0, tptr_r} < INT_LIMIT));
          pwe_nxt = wr_ok;
          paddr_nxt = tptr_r;
          pwdata_nxt = {acc_r, rd_reg(ea)};
        end
        default: flush = 1'b0;
      endcase
    end else if (dkind_r == K_TBL) begin
      we = 1'b1;
      wa = tdst_r;
      wd = tsel_r ? insn[15:8] : insn[7:0];
    end
    if (we) begin
      unique case (wa)
        SFR_IPL: begin
          ip_nxt = {iplatch_r, wd};
          flush = 1'b1;
        end
        SFR_IPLATCH: iplatch_nxt = wd;
        SFR_STATUS: flags_nxt = wd[3:0];
        SFR_ACC: acc_nxt = wd;
        SFR_PRODL: prod_nxt[7:0] = wd;
        SFR_PRODH: prod_nxt[15:8] = wd;
        SFR_TPTRL: tptr_nxt[7:0] = wd;
        SFR_TPTRH: tptr_nxt[15:8] = wd;
        SFR_FSR: fsr_nxt = wd;
        default: flush = flush;
      endcase
    end
    gpr_we = we && (wa > SFR_INDF);
    gpr_wa = wa;
    gpr_wd = wd;
    if (flush || tbl_go) begin
      dkind_nxt = K_NONE;
    end
    if (tbl_go) begin
      ip_nxt = ip_r - 16'h0001;
    end else if (run_r) begin
      paddr_nxt = ip_nxt;
      prd_nxt = 1'b1;
      akind_nxt = K_FETCH;
      ip_nxt = ip_nxt + 16'h0001;
    end
    unique case (mode_r)
      MODE_MCU, MODE_PMCU: pext_nxt = 1'b0;
      MODE_MPU: pext_nxt = 1'b1;
      MODE_EXT: pext_nxt = ({1'b0, paddr_nxt} >= INT_LIMIT);
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ip_r <= IP_RESET;
      paddr_r <= IP_RESET;
      pwdata_r <= 16'h0000;
      prd_r <= 1'b0;
      pwe_r <= 1'b0;
      pext_r <= 1'b0;
      akind_r <= K_NONE;
      dkind_r <= K_NONE;
      acc_r <= BYTE_RESET;
      iplatch_r <= BYTE_RESET;
      fsr_r <= BYTE_RESET;
      tptr_r <= 16'h0000;
      prod_r <= 16'h0000;
      flags_r <= FLAGS_RESET;
      tdst_r <= BYTE_RESET;
      tsel_r <= 1'b0;
    end else begin
      ip_r <= ip_nxt;
      paddr_r <= paddr_nxt;
      pwdata_r <= pwdata_nxt;
      prd_r <= prd_nxt;
      pwe_r <= pwe_nxt;
      pext_r <= pext_nxt;
      akind_r <= akind_nxt;
      dkind_r <= dkind_nxt;
      acc_r <= acc_nxt;
      iplatch_r <= iplatch_nxt;
      fsr_r <= fsr_nxt;
      tptr_r <= tptr_nxt;
      prod_r <= prod_nxt;
      flags_r <= flags_nxt;
      tdst_r <= tdst_nxt;
      tsel_r <= tsel_nxt;
    end
  end

  // general registers, not reset
  always_ff @(posedge clock) begin
    if (gpr_we) begin
      gpr_r[gpr_wa] <= gpr_wd;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign prog_addr = paddr_r;
  assign prog_rd = prd_r;
  assign prog_we = pwe_r;
  assign prog_wdata = pwdata_r;
  assign prog_ext = pext_r;

endmodule // cca_core

`default_nettype wire

/* verilog/cca_pkg.sv */
/*
  Shared constants and types of the 8-bit core datapath: register offsets,
  control and flag bit positions, data-memory special addresses, opcodes,
  ALU operations, execution modes and bus answers.
  Assumes compilation ahead of every other design file.
*/
`default_nettype none

package cca_pkg;

  // ==========================================================
  // widths and sizes
  localparam int unsigned INSN_W = 16;
  localparam int unsigned IP_W = 16;
  localparam int unsigned INT_WORDS_DEF = 2048;

  // ==========================================================
  // bus register offsets and answers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CORE = 8'h08;
  localparam logic [7:0] REG_PROD = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_PROT_BIT = 3;
  localparam int unsigned STAT_PROT_BIT = 8;
  localparam int unsigned STAT_IDLE_BIT = 9;

  // ==========================================================
  // status flag positions and reset values
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_NIB = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_SOV = 3;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // ==========================================================
  // data-memory addresses of core registers
  localparam logic [7:0] SFR_IPL = 8'h00;
  localparam logic [7:0] SFR_IPLATCH = 8'h01;
  localparam logic [7:0] SFR_STATUS = 8'h02;
  localparam logic [7:0] SFR_ACC = 8'h03;
  localparam logic [7:0] SFR_PRODL = 8'h04;
  localparam logic [7:0] SFR_PRODH = 8'h05;
  localparam logic [7:0] SFR_TPTRL = 8'h06;
  localparam logic [7:0] SFR_TPTRH = 8'h07;
  localparam logic [7:0] SFR_FSR = 8'h08;
  localparam logic [7:0] SFR_INDF = 8'h09;

  // ==========================================================
  // opcodes in bits 15:12
  localparam logic [3:0] OP_ALUF = 4'h0;
  localparam logic [3:0] OP_ALUL = 4'h1;
  localparam logic [3:0] OP_MOVP0 = 4'h2;
  localparam logic [3:0] OP_MOVP1 = 4'h3;
  localparam logic [3:0] OP_MUL = 4'h4;
  localparam logic [3:0] OP_GOTO = 4'h5;
  localparam logic [3:0] OP_TBLRD = 4'h6;
  localparam logic [3:0] OP_TBLWT = 4'h7;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000, ALU_ADDC = 3'b001, ALU_SUB = 3'b010, ALU_AND = 3'b011,
    ALU_IOR = 3'b100, ALU_XOR = 3'b101, ALU_RLC = 3'b110, ALU_PASS = 3'b111
  } cca_aluop_t;

  typedef enum logic [1:0] {
    MODE_MCU = 2'b00, MODE_PMCU = 2'b01, MODE_MPU = 2'b10, MODE_EXT = 2'b11
  } cca_mode_t;

  typedef enum logic [1:0] {
    K_NONE = 2'b00, K_FETCH = 2'b01, K_TBL = 2'b10
  } cca_kind_t;

endpackage : cca_pkg

`default_nettype wire
